// [ufpc_ctrl.v]
// user flash program control: mapping, access policy, launch key and programming sequencer
//
// How it works
// - user space is 32K bytes as 256 pages of 128 bytes
// - extra row holds 128 bytes inside the user flash array
// - security byte: upper nibble software writable, lower nibble read-only
// - a 128-byte column latch page stages every programming operation
// - programming only takes effect while code runs from boot flash
// - boot flash is never written by software
// - user code reads and loads; boot code also programs; external code nothing
// - after reset user space is only readable through code reads
// - latch select routes data writes 0000h-7FFFh into the column latches
// - address bits 6:0 pick the byte, bits 14:7 the page
// - latch select overrides the external RAM mapping bit
// - space select maps user, extra row or security byte for code reads
// - key 5xh then Axh unlocks and launches programming
// - busy flag in the control register shows programming in progress
// - space 00: first key no action, second programs latches into user space
// - space 01: completed key programs latches into the extra row
// - space 10: completed key programs the security fuse bits
`timescale 1ns/1ns
`default_nettype none
`include "ufpc_regs.vh"
module ufpc_ctrl
#(
  parameter PAGES       = 256,
  parameter PAGE_BYTES  = 128,
  parameter OFS_W       = 7,
  parameter PAGE_W      = 8,
  parameter PROG_CYCLES = `UFPC_PROG_CYCLES
)
(
  input  wire        clk_in,
  input  wire        reset_in,
  // register port
  input  wire [3:0]  reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [7:0]  reg_rdata_out,
  // where the current instruction was fetched from
  input  wire [1:0]  fetch_src_in,
  input  wire        external_access_pin_in,
  // data-space write from the core
  input  wire [15:0] data_addr_in,
  input  wire [7:0]  data_wdata_in,
  input  wire        data_wr_in,
  output wire        data_to_latch_out,
  output wire        data_to_xram_out,
  output wire        data_to_ext_out,
  // code_read_instruction port
  input  wire [15:0] code_addr_in,
  input  wire        code_rd_in,
  output reg  [7:0]  code_rdata_out,
  output reg         code_hit_out,
  output wire        flash_busy_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ARM  = 3'b010;
  localparam ST_PROG = 3'b100;
  localparam CNT_W   = 16;
  localparam [31:0]      PROG_LAST_W = PROG_CYCLES - 1;
  localparam [CNT_W-1:0] PROG_LAST   = PROG_LAST_W[CNT_W-1:0];

  reg  [2:0]        state_ff;
  reg  [2:0]        nxt_state;
  reg  [3:0]        key_ff;
  reg  [1:0]        space_ff;
  reg               latch_sel_ff;
  reg               external_ram_map_select_ff;
  reg  [1:0]        prog_space_ff;
  reg  [CNT_W-1:0]  cnt_ff;
  reg  [OFS_W:0]    byte_ff;
  reg  [PAGE_W-1:0] page_ff;
  reg  [7:0]        sec_ff;
  reg  [7:0]        lat_rd_nxt;
  reg               code_sec_ff;
  reg               code_hit_nxt;

  wire       wr_fc  = reg_wr_in && (reg_addr_in == `UFPC_ADDR_FLASH_CTRL);
  wire [3:0] key_in = reg_wdata_in[`UFPC_FC_KEY_HI:`UFPC_FC_KEY_LO];

  function boot_src;
    input [1:0] src;
    begin
      boot_src = (src == `UFPC_SRC_BOOT);
    end
  endfunction

  function may_load;
    input [1:0] src;
    input       ea;
    begin
      // external fetch with the access pin low gets nothing
      may_load = (src == `UFPC_SRC_USER) || (src == `UFPC_SRC_BOOT) || ea;
    end
  endfunction

  wire prog_ok  = boot_src(fetch_src_in);
  wire loadable = may_load(fetch_src_in, external_access_pin_in)
                  && (fetch_src_in != `UFPC_SRC_EXT);

  // data-space decode, latch select first
  wire in_low_half = (data_addr_in[15] == 1'b0);
  assign data_to_latch_out = latch_sel_ff && in_low_half;
  assign data_to_xram_out  = !data_to_latch_out && !external_ram_map_select_ff;
  assign data_to_ext_out   = !data_to_latch_out && external_ram_map_select_ff;
  wire lat_wr = data_wr_in && data_to_latch_out && loadable && !state_ff[2];

  // page number captured from the latch writes
  reg [PAGE_W-1:0] tgt_page_ff;
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      tgt_page_ff <= {PAGE_W{1'b0}};
    else if (lat_wr)
      tgt_page_ff <= data_addr_in[14:7];
  end

  wire [7:0] lat_data;
  wire       lat_loaded;
  wire       prog_end = state_ff[2] && (cnt_ff == PROG_LAST);

  ufpc_latch_buf #(.PAGE_BYTES(PAGE_BYTES), .OFS_W(OFS_W)) u_latch
  (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .wr_en_in      (lat_wr),
    .wr_ofs_in     (data_addr_in[6:0]),
    .wr_data_in    (data_wdata_in),
    .clear_in      (prog_end),
    .rd_ofs_in     (byte_ff[OFS_W-1:0]),
    .rd_data_out   (lat_data),
    .rd_loaded_out (lat_loaded)
  );

  // copy one latched byte per cycle during the first page-length of the operation
  wire arr_wr = state_ff[2] && !byte_ff[OFS_W] && lat_loaded
                && (prog_space_ff != `UFPC_SPACE_SEC);
  wire code_extra_row = (space_ff == `UFPC_SPACE_EXTRA_ROW);
  wire [7:0] arr_data;

  ufpc_array #(.PAGES(PAGES), .PAGE_BYTES(PAGE_BYTES), .OFS_W(OFS_W), .PAGE_W(PAGE_W)) u_array
  (
    .clk_in      (clk_in),
    .wr_en_in    (arr_wr),
    .wr_extra_row_in  (prog_space_ff == `UFPC_SPACE_EXTRA_ROW),
    .wr_page_in  (page_ff),
    .wr_ofs_in   (byte_ff[OFS_W-1:0]),
    .wr_data_in  (lat_data),
    .rd_extra_row_in  (code_extra_row),
    .rd_addr_in  (code_addr_in[14:0]),
    .rd_data_out (arr_data)
  );

  // launch key sequencer
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (wr_fc && key_in == `UFPC_KEY_FIRST)
          nxt_state = ST_ARM;
      ST_ARM:
        if (wr_fc && key_in == `UFPC_KEY_SECOND && prog_ok && space_ff != 2'h3)
          nxt_state = ST_PROG;
        else if (wr_fc)
          nxt_state = ST_IDLE;
      ST_PROG:
        if (prog_end)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_ff      <= ST_IDLE;
      key_ff        <= 4'h0;
      space_ff      <= `UFPC_SPACE_USER;
      latch_sel_ff  <= 1'b0;
      external_ram_map_select_ff     <= 1'b0;
      prog_space_ff <= `UFPC_SPACE_USER;
      cnt_ff        <= {CNT_W{1'b0}};
      byte_ff       <= {(OFS_W+1){1'b0}};
      page_ff       <= {PAGE_W{1'b0}};
      sec_ff        <= `UFPC_SEC_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
      // space select, latch select and key field are frozen while programming runs; the external RAM mapping bit still takes writes
      if (wr_fc && !state_ff[2])
      begin
        key_ff       <= key_in;
        space_ff     <= reg_wdata_in[`UFPC_FC_SPACE_HIGH:`UFPC_FC_SPACE_LOW];
        latch_sel_ff <= reg_wdata_in[`UFPC_FC_LATCH_SEL];
      end
      if (reg_wr_in && reg_addr_in == `UFPC_ADDR_AUX_CTRL)
        external_ram_map_select_ff <= reg_wdata_in[`UFPC_AUX_EXTERNAL_RAM_MAP_SELECT];
      if (state_ff[1] && nxt_state[2])
      begin
        prog_space_ff <= space_ff;
        page_ff       <= tgt_page_ff;
        cnt_ff        <= {CNT_W{1'b0}};
        byte_ff       <= {(OFS_W+1){1'b0}};
      end
      else if (state_ff[2])
      begin
        cnt_ff <= cnt_ff + 1'b1;
        if (!byte_ff[OFS_W])
          byte_ff <= byte_ff + 1'b1;
      end
      // fuse bits: only the upper nibble takes the latched value; the fuse copy wins over a software write
      if (arr_wr == 1'b0 && state_ff[2] && prog_space_ff == `UFPC_SPACE_SEC
          && byte_ff == {(OFS_W+1){1'b0}} && lat_loaded)
        sec_ff[7:4] <= lat_data[7:4];
      else if (reg_wr_in && reg_addr_in == `UFPC_ADDR_SEC_BYTE)
        sec_ff[7:4] <= reg_wdata_in[7:4];
    end
  end

  assign flash_busy_out = state_ff[2];

  // code reads: array answer one cycle later, security byte from the fuse register
  always @*
  begin
    code_hit_nxt = 1'b0;
    if (code_rd_in && fetch_src_in != `UFPC_SRC_EXT)
    begin
      case (space_ff)
        `UFPC_SPACE_USER: code_hit_nxt = !code_addr_in[15];
        `UFPC_SPACE_EXTRA_ROW: code_hit_nxt = (code_addr_in[15:7] == `UFPC_EXTRA_ROW_BASE >> 7);
        `UFPC_SPACE_SEC:  code_hit_nxt = (code_addr_in == 16'h0000);
        default:          code_hit_nxt = 1'b0;
      endcase
    end
  end

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      code_hit_out <= 1'b0;
      code_sec_ff  <= 1'b0;
    end
    else
    begin
      code_hit_out <= code_hit_nxt;
      code_sec_ff  <= (space_ff == `UFPC_SPACE_SEC);
    end
  end

  always @*
  begin
    if (!code_hit_out)
      code_rdata_out = 8'h00;
    else if (code_sec_ff)
      code_rdata_out = sec_ff;
    else
      code_rdata_out = arr_data;
  end

  // register read data, one cycle after the strobe
  always @*
  begin
    case (reg_addr_in)
      `UFPC_ADDR_FLASH_CTRL: lat_rd_nxt = {key_ff, space_ff, latch_sel_ff, state_ff[2]};
      `UFPC_ADDR_AUX_CTRL:   lat_rd_nxt = {6'h00, external_ram_map_select_ff, 1'b0};
      `UFPC_ADDR_SEC_BYTE:   lat_rd_nxt = sec_ff;
      `UFPC_ADDR_STATUS:     lat_rd_nxt = {5'h00, state_ff};
      default:               lat_rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= lat_rd_nxt;
    else
      reg_rdata_out <= 8'h00;
  end
endmodule // ufpc_ctrl
`default_nettype wire

// [ufpc_regs.vh]
// register offsets, field positions, reset values and timing counts of the flash program control
`ifndef UFPC_REGS_VH
`define UFPC_REGS_VH

// register offsets on the plain register port
`define UFPC_ADDR_FLASH_CTRL   4'h0
`define UFPC_ADDR_AUX_CTRL     4'h1
`define UFPC_ADDR_SEC_BYTE     4'h2
`define UFPC_ADDR_STATUS       4'h3

// flash_control_reg fields
`define UFPC_FC_KEY_HI         7
`define UFPC_FC_KEY_LO         4
`define UFPC_FC_SPACE_HIGH     3
`define UFPC_FC_SPACE_LOW      2
`define UFPC_FC_LATCH_SEL      1
`define UFPC_FC_BUSY           0

// auxiliary_control_reg fields
`define UFPC_AUX_EXTERNAL_RAM_MAP_SELECT        1

// launch key nibbles
`define UFPC_KEY_FIRST         4'h5
`define UFPC_KEY_SECOND        4'hA

// space select codes
`define UFPC_SPACE_USER        2'h0
`define UFPC_SPACE_EXTRA_ROW        2'h1
`define UFPC_SPACE_SEC         2'h2

// reset values
`define UFPC_FC_RESET          8'h00
`define UFPC_AUX_RESET         8'h00
`define UFPC_SEC_RESET         8'hFF

// programming time and derived cycle count at 100 MHz
`define UFPC_PROG_TIME_US      10
`define UFPC_CLK_MHZ           100
`define UFPC_PROG_CYCLES       (`UFPC_PROG_TIME_US * `UFPC_CLK_MHZ)

// fetch source codes
`define UFPC_SRC_USER          2'h0
`define UFPC_SRC_BOOT          2'h1
`define UFPC_SRC_EXT           2'h2

// extra row window base in code space
`define UFPC_EXTRA_ROW_BASE         16'hFF80

`endif

// [ufpc_latch_buf.v]
// page-wide column latch buffer with per-byte load flags
`timescale 1ns/1ns
`default_nettype none
module ufpc_latch_buf
#(
  parameter PAGE_BYTES = 128,
  parameter OFS_W      = 7
)
(
  input  wire             clk_in,
  input  wire             reset_in,
  input  wire             wr_en_in,
  input  wire [OFS_W-1:0] wr_ofs_in,
  input  wire [7:0]       wr_data_in,
  input  wire             clear_in,
  input  wire [OFS_W-1:0] rd_ofs_in,
  output wire [7:0]       rd_data_out,
  output wire             rd_loaded_out
);
  reg [7:0]            mem_ff [0:PAGE_BYTES-1];
  reg [PAGE_BYTES-1:0] loaded_ff;
  integer              i;

  // storage has no reset; only the load flags need a defined state
  always @(posedge clk_in)
  begin
    if (wr_en_in)
      mem_ff[wr_ofs_in] <= wr_data_in;
  end

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      loaded_ff <= {PAGE_BYTES{1'b0}};
    else
    begin
      for (i = 0; i < PAGE_BYTES; i = i + 1)
      begin
        if (wr_en_in && (wr_ofs_in == i[OFS_W-1:0]))
          loaded_ff[i] <= 1'b1;
        else if (clear_in)
          loaded_ff[i] <= 1'b0;
      end
    end
  end

  assign rd_data_out   = mem_ff[rd_ofs_in];
  assign rd_loaded_out = loaded_ff[rd_ofs_in];
endmodule // ufpc_latch_buf
`default_nettype wire

// [ufpc_array.v]
// flash storage model: user space pages and the extra row, programmed from the column latches
`timescale 1ns/1ns
`default_nettype none
module ufpc_array
#(
  parameter PAGES      = 256,
  parameter PAGE_BYTES = 128,
  parameter OFS_W      = 7,
  parameter PAGE_W     = 8
)
(
  input  wire              clk_in,
  input  wire              wr_en_in,
  input  wire              wr_extra_row_in,
  input  wire [PAGE_W-1:0] wr_page_in,
  input  wire [OFS_W-1:0]  wr_ofs_in,
  input  wire [7:0]        wr_data_in,
  input  wire              rd_extra_row_in,
  input  wire [14:0]       rd_addr_in,
  output reg  [7:0]        rd_data_out
);
  reg [7:0] user_ff [0:PAGES*PAGE_BYTES-1];
  reg [7:0] extra_row_ff [0:PAGE_BYTES-1];

  always @(posedge clk_in)
  begin
    if (wr_en_in && wr_extra_row_in)
      extra_row_ff[wr_ofs_in] <= wr_data_in;
    else if (wr_en_in)
      user_ff[{wr_page_in, wr_ofs_in}] <= wr_data_in;
  end

  // registered read gives the one-cycle read latency of the code port
  always @(posedge clk_in)
  begin
    if (rd_extra_row_in)
      rd_data_out <= extra_row_ff[rd_addr_in[OFS_W-1:0]];
    else
      rd_data_out <= user_ff[rd_addr_in];
  end
endmodule // ufpc_array
`default_nettype wire

// [ufpc_ctrl_sva.sv]
// assertion checker for the flash program control ports
`timescale 1ns/1ns
`default_nettype none
`include "ufpc_regs.vh"
module ufpc_ctrl_chk
#(
  parameter PROG_CYCLES = 20
)
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [1:0]  fetch_src_in,
  input wire logic [15:0] data_addr_in,
  input wire logic        data_to_latch_out,
  input wire logic        data_to_xram_out,
  input wire logic        data_to_ext_out,
  input wire logic        code_rd_in,
  input wire logic [7:0]  code_rdata_out,
  input wire logic        code_hit_out,
  input wire logic        flash_busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [15:0] busy_cnt_ff;
  wire ctrl_wr = reg_wr_in && reg_addr_in == `UFPC_ADDR_FLASH_CTRL;
  wire key_ok = ctrl_wr && reg_wdata_in[7:4] == `UFPC_KEY_SECOND && fetch_src_in == `UFPC_SRC_BOOT;
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
      busy_cnt_ff <= 16'h0000;
    else
      busy_cnt_ff <= flash_busy_out ? busy_cnt_ff + 16'h0001 : 16'h0000;
  property p_latch_range;
    data_to_latch_out |-> !data_addr_in[15];
  endproperty
  a_latch_range: assert property (p_latch_range) else $error("latch decode above 7FFFh");
  property p_latch_prio;
    data_to_latch_out |-> !data_to_xram_out && !data_to_ext_out;
  endproperty
  a_latch_prio: assert property (p_latch_prio) else $error("latch and xram decoded together");
  property p_ext_nohit;
    code_rd_in && fetch_src_in == `UFPC_SRC_EXT |=> !code_hit_out;
  endproperty
  a_ext_nohit: assert property (p_ext_nohit) else $error("external code read hit");
  property p_hit_cause;
    code_hit_out |-> $past(code_rd_in);
  endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("hit without code read");
  property p_launch;
    $rose(flash_busy_out) |-> $past(key_ok);
  endproperty
  a_launch: assert property (p_launch) else $error("busy without second key from boot");
  property p_user_noprog;
    ctrl_wr && fetch_src_in != `UFPC_SRC_BOOT && !flash_busy_out |=> !flash_busy_out;
  endproperty
  a_user_noprog: assert property (p_user_noprog) else $error("launch from non-boot source");
  property p_busy_len;
    $fell(flash_busy_out) |-> busy_cnt_ff == PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_max;
    flash_busy_out |-> busy_cnt_ff < PROG_CYCLES;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_read;
    reg_rd_in && reg_addr_in == `UFPC_ADDR_FLASH_CTRL && flash_busy_out ##1 flash_busy_out |-> reg_rdata_out[0];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit not read");
  property p_sec_low;
    reg_rd_in && reg_addr_in == `UFPC_ADDR_SEC_BYTE |=> reg_rdata_out[3:0] == 4'hF;
  endproperty
  a_sec_low: assert property (p_sec_low) else $error("security low nibble changed");
  c_launch: cover property ($rose(flash_busy_out));
  c_latch: cover property (data_to_latch_out);
  c_hit: cover property (code_hit_out);
endmodule // ufpc_ctrl_chk
bind ufpc_ctrl ufpc_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .fetch_src_in(fetch_src_in),
  .data_addr_in(data_addr_in), .data_to_latch_out(data_to_latch_out), .data_to_xram_out(data_to_xram_out),
  .data_to_ext_out(data_to_ext_out), .code_rd_in(code_rd_in), .code_rdata_out(code_rdata_out),
  .code_hit_out(code_hit_out), .flash_busy_out(flash_busy_out));
`default_nettype wire

// [ufpc_core_model.sv]
// behavioural core: fetch source, data-space writes and code reads
`timescale 1ns/1ns
`default_nettype none
module ufpc_core_model
(
  input  wire logic        clk_in,
  input  wire logic [7:0]  code_rdata_in,
  input  wire logic        code_hit_in,
  output var  logic [1:0]  fetch_src_out,
  output var  logic        ea_out,
  output var  logic [15:0] data_addr_out,
  output var  logic [7:0]  data_wdata_out,
  output var  logic        data_wr_out,
  output var  logic [15:0] code_addr_out,
  output var  logic        code_rd_out
);
  // external access pin low: external code gets nothing
  initial
  begin
    fetch_src_out = 2'h1;
    ea_out = 1'h0;
    data_addr_out = 16'h0000;
    data_wdata_out = 8'h00;
    data_wr_out = 1'h0;
    code_addr_out = 16'h0000;
    code_rd_out = 1'h0;
  end
  task automatic set_src(input logic [1:0] s);
    @(posedge clk_in);
    fetch_src_out <= s;
  endtask
  // released lines show the inverse so stale values never match
  task automatic load(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    data_addr_out <= a;
    data_wdata_out <= d;
    data_wr_out <= 1'h1;
    @(posedge clk_in);
    data_wr_out <= 1'h0;
    data_addr_out <= ~a;
    data_wdata_out <= ~d;
  endtask
  task automatic fetch(input logic [15:0] a, output logic [8:0] r);
    @(posedge clk_in);
    code_addr_out <= a;
    code_rd_out <= 1'h1;
    @(posedge clk_in);
    code_rd_out <= 1'h0;
    code_addr_out <= ~a;
    #1;
    r = {code_hit_in, code_rdata_in};
  endtask
endmodule // ufpc_core_model
`default_nettype wire

// [ufpc_ctrl_tb.sv]
// self-checking bench for the flash program control
`timescale 1ns/1ns
`default_nettype none
`include "ufpc_regs.vh"
module ufpc_ctrl_tb;
  localparam logic [3:0] CTL = `UFPC_ADDR_FLASH_CTRL;
  localparam logic [3:0] SEC = `UFPC_ADDR_SEC_BYTE;
  logic clk_in = 1'h0;
  logic reset_in = 1'h1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  wire [7:0] reg_rdata_out, code_rdata_out, dwd;
  wire code_hit_out, flash_busy_out, lat, xr, ext, ea, dwr, crd;
  wire [1:0] src;
  wire [15:0] daddr, caddr;
  int errors = 0;
  int samples_checked = 0;
  int n;
  logic [8:0] r;
  always #5 clk_in = ~clk_in;
  ufpc_ctrl #(.PROG_CYCLES(20)) u_dut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .fetch_src_in(src), .external_access_pin_in(ea), .data_addr_in(daddr), .data_wdata_in(dwd),
    .data_wr_in(dwr), .data_to_latch_out(lat), .data_to_xram_out(xr), .data_to_ext_out(ext),
    .code_addr_in(caddr), .code_rd_in(crd), .code_rdata_out(code_rdata_out), .code_hit_out(code_hit_out),
    .flash_busy_out(flash_busy_out));
  ufpc_core_model u_core (.clk_in(clk_in), .code_rdata_in(code_rdata_out), .code_hit_in(code_hit_out),
    .fetch_src_out(src), .ea_out(ea), .data_addr_out(daddr), .data_wdata_out(dwd), .data_wr_out(dwr),
    .code_addr_out(caddr), .code_rd_out(crd));
  task automatic chk(input string w, input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1;
    chk("register", {1'h0, reg_rdata_out}, {1'h0, e});
  endtask
  task automatic code(input logic [15:0] a, input logic [8:0] e);
    u_core.fetch(a, r);
    chk("code read", r, e);
  endtask
  task automatic launch(input logic [3:0] m);
    wr(CTL, {`UFPC_KEY_FIRST, m});
    wr(CTL, {`UFPC_KEY_SECOND, m});
  endtask
  task automatic busy_is(input logic e);
    #1;
    chk("busy", {8'h00, flash_busy_out}, {8'h00, e});
  endtask
  // counts the edges from now until busy drops
  task automatic wait_idle(input logic [8:0] e);
    n = 0;
    #1;
    while (flash_busy_out === 1'h1 && n < 200)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("busy cycles", n[8:0], e);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #50000;
    errors++;
    finish_test;
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'h0;
    rd(CTL, `UFPC_FC_RESET);
    rd(`UFPC_ADDR_AUX_CTRL, `UFPC_AUX_RESET);
    rd(SEC, `UFPC_SEC_RESET);
    rd(4'hF, 8'h00);
    chk("latch decode", {8'h00, lat}, 9'h000);
    $display("test reset done");
    wr(`UFPC_ADDR_AUX_CTRL, 8'h02);
    #1;
    chk("ext decode", {7'h00, ext, xr}, 9'h002);
    wr(CTL, 8'h02);
    #1;
    chk("latch priority", {6'h00, lat, ext, xr}, 9'h004);
    u_core.set_src(`UFPC_SRC_USER);
    for (int i = 0; i < 4; i++)
      u_core.load(16'h0180 + i[15:0], 8'h11 + i[7:0]);
    launch(4'h0);
    busy_is(1'h0);
    u_core.set_src(`UFPC_SRC_BOOT);
    launch(4'h0);
    rd(CTL, 8'hA1);
    wait_idle(9'h012);
    u_core.set_src(`UFPC_SRC_USER);
    for (int i = 0; i < 4; i++)
      code(16'h0180 + i[15:0], {1'h1, 8'h11 + i[7:0]});
    code(16'h8000, 9'h000);
    u_core.set_src(`UFPC_SRC_EXT);
    code(16'h0180, 9'h000);
    $display("test user program done");
    u_core.set_src(`UFPC_SRC_BOOT);
    wr(CTL, 8'h50);
    wr(CTL, 8'h30);
    wr(CTL, 8'hA0);
    busy_is(1'h0);
    launch(4'h0);
    launch(4'h0);
    wait_idle(9'h010);
    $display("test key sequence done");
    wr(CTL, 8'h02);
    u_core.load(16'h0005, 8'h3C);
    launch(4'h4);
    wait_idle(9'h014);
    wr(CTL, 8'h04);
    code(16'hFF85, 9'h13C);
    code(16'h0005, 9'h000);
    $display("test extra row done");
    wr(CTL, 8'h02);
    u_core.load(16'h0000, 8'h5A);
    launch(4'h8);
    wait_idle(9'h014);
    rd(SEC, 8'h5F);
    wr(SEC, 8'h30);
    rd(SEC, 8'h3F);
    wr(CTL, 8'h08);
    code(16'h0000, 9'h13F);
    launch(4'hC);
    busy_is(1'h0);
    $display("test security byte done");
    finish_test;
  end
endmodule // ufpc_ctrl_tb
`default_nettype wire
